//--- hdl/sio_pkg.sv
// constants for the switched io status and control block
package sio_pkg;
    localparam int unsigned NUM_SW       = 4;
    localparam int unsigned CNT_W        = 16;
    localparam int unsigned BYTE_W       = 8;
    // cyclic status bytes (device to controller)
    localparam int unsigned STAT_LEVEL_IDX = 0;
    localparam int unsigned STAT_CMP_IDX   = 1;
    // cyclic command bytes (controller to device)
    localparam int unsigned CMD_DRIVE_IDX  = 0;
    localparam int unsigned CMD_SPARE_IDX  = 1;
    // field positions
    localparam int unsigned CMD_DRIVE_LSB  = 0;
    localparam int unsigned CMD_CLEAR_LSB  = 4;
    localparam int unsigned CMP_STATE_OFS  = 0;
    localparam int unsigned CMP_TOGGLE_OFS = 1;
    // compare mode encodings
    localparam logic MODE_ONCE  = 1'b0;
    localparam logic MODE_MULTI = 1'b1;
    // reset values, counter maximum and counter step
    localparam logic [7:0]  STAT_RESET = 8'h00;
    localparam logic [7:0]  CMD_RESET  = 8'h00;
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
endpackage

//--- hdl/sio_status_control.sv
// switched io status and control: cyclic status and command bytes
// Operation
// - status byte 0 bits 0..3 show the level of each switching pin.
// - even bits of status byte 1 flag a counter past its compare value.
// - comparison bit returns to zero whenever its counter is reset.
// - in multiple-switch mode the odd toggle bit inverts on every exceedance.
// - command byte 0 bits 0..3 drive switching outputs one to four.
// - command one means active output; zero means inactive only while the pin's comparison bit is clear.
// - rising command bits 4..7 clear counters 1..4; falling does nothing.
// - 16-bit activation count fires at compare value; deactivation clears it.
// - compare mode picks switch once on equality or repeatedly at or above.
`timescale 1ns/100ps
`default_nettype none
module sio_status_control #(
    parameter int unsigned NUM_SW = sio_pkg::NUM_SW,
    parameter int unsigned CNT_W  = sio_pkg::CNT_W
) (
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    // cyclic command data from the controller
    input  wire logic                      cmd_valid_i,
    input  wire logic [7:0]                cmd_byte0_i,
    input  wire logic [7:0]                cmd_byte1_i,
    // cyclic status data to the controller
    output logic      [7:0]                status_byte0_o,
    output logic      [7:0]                status_byte1_o,
    // per-pin configuration from neighbouring logic
    input  wire logic [NUM_SW-1:0]         pin_is_output_i,
    input  wire logic [NUM_SW-1:0]         compare_mode_i,
    input  wire logic [NUM_SW*CNT_W-1:0]   compare_value_i,
    // activation function events, one-cycle pulses
    input  wire logic [NUM_SW-1:0]         activation_function_evt_i,
    input  wire logic [NUM_SW-1:0]         deactivation_evt_i,
    // switching pins
    input  wire logic [NUM_SW-1:0]         switched_io_pin_i,
    output logic      [NUM_SW-1:0]         switching_output_pin_o,
    output logic      [NUM_SW-1:0]         switched_io_oe_n_o
);

    typedef struct packed {
        logic [NUM_SW-1:0]            sync1;
        logic [NUM_SW-1:0]            sync2;
        logic [NUM_SW-1:0]            sync3;
        logic [NUM_SW-1:0]            level;
        logic [7:0]                   cmd_prev;
        logic [NUM_SW-1:0][CNT_W-1:0] cnt;
        logic [NUM_SW-1:0]            cmp;
        logic [NUM_SW-1:0]            tog;
        logic [NUM_SW-1:0]            drive;
        logic [NUM_SW-1:0]            oe_n;
        logic [7:0]                   stat0;
        logic [7:0]                   stat1;
    } sio_state_t;

    sio_state_t s_q;
    sio_state_t s_d;
    logic [NUM_SW-1:0] clr_rise;

    always_comb begin
        logic [CNT_W-1:0] cnt_n;
        logic [CNT_W-1:0] cmp_val;
        logic             hit;
        cnt_n   = '0;
        cmp_val = '0;
        hit     = 1'b0;
        s_d     = s_q;
        // pin level passes three flops; accept once stages two and three agree
        s_d.sync1 = switched_io_pin_i;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        for (int i = 0; i < NUM_SW; i++) begin
            if (s_q.sync2[i] == s_q.sync3[i]) begin
                s_d.level[i] = s_q.sync3[i];
            end
        end
        // rising edge against the held command; spare byte not used
        clr_rise = '0;
        if (cmd_valid_i) begin
            clr_rise = cmd_byte0_i[sio_pkg::CMD_CLEAR_LSB +: NUM_SW]
                     & ~s_q.cmd_prev[sio_pkg::CMD_CLEAR_LSB +: NUM_SW];
            s_d.cmd_prev = cmd_byte0_i;
        end
        for (int i = 0; i < NUM_SW; i++) begin
            cmp_val = compare_value_i[i*CNT_W +: CNT_W];
            cnt_n   = s_q.cnt[i];
            hit     = 1'b0;
            if (activation_function_evt_i[i]
                    && s_q.cnt[i] != CNT_W'(sio_pkg::CNT_MAX)) begin
                cnt_n = s_q.cnt[i] + CNT_W'(sio_pkg::CNT_ONE);
                // once on equality, repeatedly at or above
                if (compare_mode_i[i] == sio_pkg::MODE_MULTI) begin
                    hit = (cnt_n >= cmp_val);
                end else begin
                    hit = (cnt_n == cmp_val);
                end
            end
            // a hit that meets a clear is dropped, toggle included
            if (hit && !(clr_rise[i] || deactivation_evt_i[i])) begin
                s_d.cmp[i] = 1'b1;
                // toggle on every exceedance in multi mode
                if (compare_mode_i[i] == sio_pkg::MODE_MULTI) begin
                    s_d.tog[i] = ~s_q.tog[i];
                end
            end
            // deactivation clears; clear wins over a same-cycle hit
            if (clr_rise[i] || deactivation_evt_i[i]) begin
                cnt_n      = CNT_W'(sio_pkg::CNT_RESET);
                s_d.cmp[i] = 1'b0;
            end
            s_d.cnt[i] = cnt_n;
        end
        // command bit one or a set comparison bit activates; zero deactivates only without a comparison hit
        s_d.drive = s_d.cmd_prev[sio_pkg::CMD_DRIVE_LSB +: NUM_SW] | s_d.cmp;
        s_d.oe_n  = ~pin_is_output_i;
        // pin levels in the low nibble
        s_d.stat0 = sio_pkg::STAT_RESET;
        s_d.stat0[NUM_SW-1:0] = s_d.level;
        s_d.stat1 = sio_pkg::STAT_RESET;
        for (int i = 0; i < NUM_SW; i++) begin
            s_d.stat1[2*i + sio_pkg::CMP_STATE_OFS]  = s_d.cmp[i];
            s_d.stat1[2*i + sio_pkg::CMP_TOGGLE_OFS] = s_d.tog[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign status_byte0_o         = s_q.stat0;
    assign status_byte1_o         = s_q.stat1;
    assign switching_output_pin_o = s_q.drive;
    assign switched_io_oe_n_o     = s_q.oe_n;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_level_upper_zero;
        status_byte0_o[7:NUM_SW] == '0;
    endproperty
    a_level_upper_zero: assert property (p_level_upper_zero)
        else $error("status byte 0 upper bits not zero");

    property p_level_follows;
        (s_q.sync2 == s_q.sync3)
            |=> status_byte0_o[NUM_SW-1:0] == $past(s_q.sync3);
    endproperty
    a_level_follows: assert property (p_level_follows)
        else $error("pin level not reported after sync agreed");

    property p_drive_cmd;
        cmd_valid_i && cmd_byte0_i[0] |=> switching_output_pin_o[0];
    endproperty
    a_drive_cmd: assert property (p_drive_cmd)
        else $error("output 1 not active after command one");

    property p_drive_off;
        cmd_valid_i && !cmd_byte0_i[0] && !s_d.cmp[0]
            |=> !switching_output_pin_o[0];
    endproperty
    a_drive_off: assert property (p_drive_off)
        else $error("output 1 active after command zero");

    property p_spare_ignored;
        cmd_valid_i |=> s_q.cmd_prev == $past(cmd_byte0_i);
    endproperty
    a_spare_ignored: assert property (p_spare_ignored)
        else $error("held command not the last command byte 0");

    property p_reset_clear;
        $fell(reset_i) |-> status_byte0_o == '0 && status_byte1_o == '0
            && switching_output_pin_o == '0;
    endproperty
    a_reset_clear: assert property (@(posedge clk_i) p_reset_clear)
        else $error("status not zero after reset");

    for (genvar g = 0; g < NUM_SW; g++) begin : g_chk
        property p_cmp_rise;
            $rose(s_q.cmp[g]) |-> $past(activation_function_evt_i[g])
                && s_q.cnt[g] != '0;
        endproperty
        a_cmp_rise: assert property (p_cmp_rise)
            else $error("comparison bit set without activation");

        property p_clear;
            clr_rise[g] |=> s_q.cnt[g] == '0 && !s_q.cmp[g]
                && !status_byte1_o[2*g];
        endproperty
        a_clear: assert property (p_clear)
            else $error("counter clear did not reset comparison state");

        property p_toggle;
            $changed(s_q.tog[g])
                |-> $past(compare_mode_i[g] == sio_pkg::MODE_MULTI
                && activation_function_evt_i[g]);
        endproperty
        a_toggle: assert property (p_toggle)
            else $error("toggle bit changed outside multi-mode exceedance");

        property p_fall_no_clear;
            cmd_valid_i && !cmd_byte0_i[sio_pkg::CMD_CLEAR_LSB + g]
                && !deactivation_evt_i[g]
                && !activation_function_evt_i[g]
                |=> s_q.cnt[g] == $past(s_q.cnt[g]);
        endproperty
        a_fall_no_clear: assert property (p_fall_no_clear)
            else $error("counter changed without cause");

        property p_count;
            activation_function_evt_i[g] && !clr_rise[g]
                && !deactivation_evt_i[g]
                && s_q.cnt[g] != CNT_W'(sio_pkg::CNT_MAX)
                |=> s_q.cnt[g]
                    == $past(s_q.cnt[g]) + CNT_W'(sio_pkg::CNT_ONE);
        endproperty
        a_count: assert property (p_count)
            else $error("counter did not advance on activation");

        property p_deact;
            deactivation_evt_i[g] |=> s_q.cnt[g] == '0;
        endproperty
        a_deact: assert property (p_deact)
            else $error("deactivation did not clear counter");
    end

    c_toggle: cover property (s_q.tog[0] ##[1:50] !s_q.tog[0]);
    c_cmp_once: cover property ($rose(s_q.cmp[1])
        && compare_mode_i[1] == sio_pkg::MODE_ONCE);
    c_clear_cmd: cover property (s_q.cmp[0] ##1 !s_q.cmp[0]
        && $past(clr_rise[0]));
    c_level: cover property ($rose(status_byte0_o[3]));

endmodule // sio_status_control
`default_nettype wire

//--- verification/sio_ctrl_model.sv
// controller model: sends cyclic command bytes, counts toggle changes
`timescale 1ns/100ps
`default_nettype none
module sio_ctrl_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // bench request
    input  wire logic       send_i,
    input  wire logic [7:0] byte_i,
    // cyclic command data
    output logic            cmd_valid_o,
    output logic      [7:0] cmd_byte0_o,
    output logic      [7:0] cmd_byte1_o,
    // cyclic status data
    input  wire logic [7:0] status_byte1_i,
    output logic      [7:0] hits_o
);
    logic tog_q;
    always @(posedge clk_i) begin
        cmd_valid_o <= send_i & ~reset_i;
        tog_q <= status_byte1_i[1];
        // spare byte never rests, so any use of it shows
        cmd_byte1_o <= reset_i ? 8'h00 : cmd_byte1_o + 8'h5b;
        if (reset_i) cmd_byte0_o <= 8'h00;
        else if (send_i) cmd_byte0_o <= byte_i;
        // each toggle change is one more exceedance
        if (reset_i) hits_o <= 8'h00;
        else if (status_byte1_i[1] != tog_q) hits_o <= hits_o + 8'h01;
    end
endmodule // sio_ctrl_model
`default_nettype wire

//--- verification/switched_io_status_control_tb.sv
// bench for the switched io status and control block
`timescale 1ns/100ps
`default_nettype none
module switched_io_status_control_tb;
    logic clk_i = 1'b0, reset_i = 1'b1, send = 1'b0, vld;
    logic [7:0] sbyte = 8'h00, b0, b1, st0, st1, hits;
    logic [3:0] is_out = 4'h3, mode = 4'h1, act = 4'h0, deact = 4'h0;
    logic [3:0] pins = 4'h0, out, oe_n;
    logic [63:0] cval = 64'h0000_0000_0001_0002;
    int fails = 0, checks = 0;
    sio_ctrl_model ctrl (.clk_i(clk_i), .reset_i(reset_i), .send_i(send),
        .byte_i(sbyte), .cmd_valid_o(vld), .cmd_byte0_o(b0),
        .cmd_byte1_o(b1), .status_byte1_i(st1), .hits_o(hits));
    sio_status_control dut (.clk_i(clk_i), .reset_i(reset_i),
        .cmd_valid_i(vld), .cmd_byte0_i(b0), .cmd_byte1_i(b1),
        .status_byte0_o(st0), .status_byte1_o(st1),
        .pin_is_output_i(is_out), .compare_mode_i(mode),
        .compare_value_i(cval), .activation_function_evt_i(act),
        .deactivation_evt_i(deact), .switched_io_pin_i(pins),
        .switching_output_pin_o(out), .switched_io_oe_n_o(oe_n));
    initial forever #20 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b);
        @(posedge clk_i) begin send <= 1'b1; sbyte <= b; end
        @(posedge clk_i) send <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(input logic [3:0] a, d);
        @(posedge clk_i) begin act <= a; deact <= d; end
        @(posedge clk_i) begin act <= 4'h0; deact <= 4'h0; end
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic t_reset_and_pins();
        #1;
        chk("status0", 8'h00, st0);
        chk("status1", 8'h00, st1);
        @(posedge clk_i) pins <= 4'ha;
        repeat (8) @(posedge clk_i);
        #1;
        chk("pin levels", 8'h0a, st0);
        chk("oe_n", 8'h0c, {4'h0, oe_n});
    endtask
    task automatic t_drive();
        cmd(8'h0f);
        chk("out all", 8'h0f, {4'h0, out});
        cmd(8'h05);
        chk("out mixed", 8'h05, {4'h0, out});
    endtask
    task automatic t_multi();
        pulse(4'h1, 4'h0);
        chk("cmp below", 8'h00, st1 & 8'h03);
        pulse(4'h1, 4'h0);
        chk("cmp reach", 8'h03, st1 & 8'h03);
        pulse(4'h1, 4'h0);
        chk("toggle again", 8'h01, st1 & 8'h03);
        chk("hits", 8'h02, hits);
        cmd(8'h10);
        chk("after clear", 8'h00, st1 & 8'h01);
        chk("out cleared", 8'h00, {4'h0, out});
        pulse(4'h1, 4'h0);
        cmd(8'h10);
        pulse(4'h1, 4'h0);
        chk("held bit no clear", 8'h01, st1 & 8'h01);
        cmd(8'h00);
        chk("fall no clear", 8'h01, st1 & 8'h01);
    endtask
    task automatic t_once();
        pulse(4'h2, 4'h0);
        chk("once hit", 8'h04, st1 & 8'h0c);
        pulse(4'h2, 4'h0);
        chk("once sticky", 8'h04, st1 & 8'h0c);
        pulse(4'h0, 4'h2);
        chk("deactivated", 8'h00, st1 & 8'h0c);
    endtask
    task automatic t_mid_reset();
        cmd(8'h10);
        @(posedge clk_i) reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        chk("reset status0", 8'h00, st0);
        chk("reset status1", 8'h00, st1);
        chk("reset out", 8'h00, {4'h0, out});
        pulse(4'h1, 4'h0);
        cmd(8'h10);
        pulse(4'h1, 4'h0);
        chk("held cmd zero", 8'h00, st1 & 8'h01);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset_and_pins();
        t_drive();
        t_multi();
        t_once();
        t_mid_reset();
        summarize();
    end
    initial begin
        #200000;
        fails++;
        summarize();
    end
endmodule // switched_io_status_control_tb
`default_nettype wire
